// file: bsw_pkg.sv
// Purpose: constants for the bridge secondary status and window block
// Assumes: 32-bit configuration dwords, byte enables per lane
// Notes:   offsets are byte addresses of the configuration dwords
package bsw_pkg;
    localparam logic [7:0]  BSW_OFS_SEC_STATUS = 8'h1C;
    localparam logic [7:0]  BSW_OFS_MEM_WIN    = 8'h20;
    localparam logic [7:0]  BSW_OFS_PREF_WIN   = 8'h24;
    // status bit positions within the dword
    localparam int          BSW_BIT_66MHZ      = 21;
    localparam int          BSW_BIT_FAST_B2B   = 23;
    localparam int          BSW_BIT_MPERR      = 24;
    localparam int          BSW_BIT_TIMING_LO  = 25;
    localparam int          BSW_BIT_TIMING_HI  = 26;
    localparam int          BSW_BIT_SIG_ABORT  = 27;
    localparam int          BSW_BIT_RX_ABORT   = 28;
    localparam int          BSW_BIT_RX_UR      = 29;
    localparam int          BSW_BIT_RX_SERR    = 30;
    localparam int          BSW_BIT_DET_PERR   = 31;
    // window field positions, field values and reset constants
    localparam int          BSW_BASE_LSB       = 4;
    localparam int          BSW_LIMIT_LSB      = 20;
    localparam int          BSW_PREF_IND_B_LSB = 0;
    localparam int          BSW_PREF_IND_L_LSB = 16;
    localparam logic [3:0]  BSW_PREF_IND_VAL   = 4'h1;
    localparam logic [11:0] BSW_ADDR_FIELD_RST = 12'h000;
    localparam logic [19:0] BSW_LOW_ZEROS      = 20'h00000;
    localparam logic [19:0] BSW_LOW_ONES       = 20'hFFFFF;
    localparam logic [31:0] BSW_UPPER_ZERO     = 32'h00000000;
    localparam logic        BSW_FLAG_RST       = 1'b0;
endpackage : bsw_pkg

// file: bsw_regs.sv
// Purpose: secondary status flags and memory window registers of a bridge
// Assumes: events and control bits come from logic on sys_clk
// Notes:   config read data and ack appear one cycle after the request
`timescale 1ns/1ns
module bsw_regs
    import bsw_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // configuration access
    input  wire logic        cfg_wr_en,
    input  wire logic        cfg_rd_en,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata_r,
    output logic             cfg_ack_r,
    // bridge control bits
    input  wire logic        ctl_parity_resp_en,
    input  wire logic        ctl_serr_fwd_en,
    // secondary side events
    input  wire logic        ev_parity_err,
    input  wire logic        ev_cpl_abort_sent,
    input  wire logic        ev_rx_abort,
    input  wire logic        ev_rx_ur,
    input  wire logic        ev_err_msg_sent,
    input  wire logic        ev_poison_rx,
    input  wire logic        sec_err_msg,
    output logic             err_fwd_r,
    // memory transaction decode
    input  wire logic        txn_valid,
    input  wire logic [63:0] txn_addr,
    input  wire logic [31:0] pref_base_upper,
    input  wire logic [31:0] pref_limit_upper,
    output logic             fwd_valid_r,
    output logic             fwd_mem_hit_r,
    output logic             fwd_pref_hit_r
);
    ////////////////////////////////////////////////////////////////////////////
    logic        mperr_r,  sig_abort_r, rx_abort_r;
    logic        rx_ur_r,  rx_serr_r,   det_perr_r;
    logic [11:0] mem_base_r,  mem_limit_r;
    logic [11:0] pref_base_r, pref_limit_r;

    wire         wr_stat = cfg_wr_en && cfg_addr == BSW_OFS_SEC_STATUS;
    wire         wr_mem  = cfg_wr_en && cfg_addr == BSW_OFS_MEM_WIN;
    wire         wr_pref = cfg_wr_en && cfg_addr == BSW_OFS_PREF_WIN;
    // only lane 3 carries clearable flags
    wire [31:0]  w1c     = (wr_stat && cfg_be[3]) ? cfg_wdata : 32'h00000000;

    // field merge honours the two lanes each 12-bit field straddles
    function automatic logic [11:0] bsw_merge(input logic [11:0] cur,
                                              input logic [11:0] nw,
                                              input logic        be_lo,
                                              input logic        be_hi);
        logic [11:0] r;
        r = cur;
        if (be_lo) r[3:0] = nw[3:0];
        if (be_hi) r[11:4] = nw[11:4];
        return r;
    endfunction : bsw_merge

    wire [11:0] mem_base_nxt   = wr_mem ? bsw_merge(mem_base_r,
        cfg_wdata[15:4], cfg_be[0], cfg_be[1]) : mem_base_r;
    wire [11:0] mem_limit_nxt  = wr_mem ? bsw_merge(mem_limit_r,
        cfg_wdata[31:20], cfg_be[2], cfg_be[3]) : mem_limit_r;
    wire [11:0] pref_base_nxt  = wr_pref ? bsw_merge(pref_base_r,
        cfg_wdata[15:4], cfg_be[0], cfg_be[1]) : pref_base_r;
    wire [11:0] pref_limit_nxt = wr_pref ? bsw_merge(pref_limit_r,
        cfg_wdata[31:20], cfg_be[2], cfg_be[3]) : pref_limit_r;

    // set beats clear so a coincident event is never lost
    wire mperr_nxt    = (ev_parity_err && ctl_parity_resp_en)
                        || (mperr_r && !w1c[BSW_BIT_MPERR]);
    wire sig_abort_nxt = ev_cpl_abort_sent || sig_abort_r;
    wire rx_abort_nxt  = ev_rx_abort || rx_abort_r;
    wire rx_ur_nxt     = ev_rx_ur || rx_ur_r;
    wire rx_serr_nxt  = (ev_err_msg_sent && ctl_serr_fwd_en)
                        || (rx_serr_r && !w1c[BSW_BIT_RX_SERR]);
    wire det_perr_nxt = ev_poison_rx
                        || (det_perr_r && !w1c[BSW_BIT_DET_PERR]);

    ////////////////////////////////////////////////////////////////////////////
    // read mux; reserved and legacy bits are zero
    wire [31:0] stat_rd = {det_perr_r, rx_serr_r, rx_ur_r, rx_abort_r,
                           sig_abort_r, 2'b00, mperr_r, 1'b0, 1'b0,
                           1'b0, 5'b00000, 16'h0000};
    wire [31:0] mem_rd  = {mem_limit_r, 4'h0, mem_base_r, 4'h0};
    wire [31:0] pref_rd = {pref_limit_r, BSW_PREF_IND_VAL,
                           pref_base_r, BSW_PREF_IND_VAL};
    wire [31:0] rd_mux  = (cfg_addr == BSW_OFS_SEC_STATUS) ? stat_rd :
                          (cfg_addr == BSW_OFS_MEM_WIN)    ? mem_rd  :
                          (cfg_addr == BSW_OFS_PREF_WIN)   ? pref_rd :
                          32'h00000000;
    wire [31:0] rdata_nxt = cfg_rd_en ? rd_mux : cfg_rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // window decode; memory window is 32-bit only
    wire [63:0] mem_lo  = {BSW_UPPER_ZERO, mem_base_r, BSW_LOW_ZEROS};
    wire [63:0] mem_hi  = {BSW_UPPER_ZERO, mem_limit_r, BSW_LOW_ONES};
    wire [63:0] pref_lo = {pref_base_upper, pref_base_r, BSW_LOW_ZEROS};
    wire [63:0] pref_hi = {pref_limit_upper, pref_limit_r, BSW_LOW_ONES};
    wire mem_hit_nxt  = txn_valid && txn_addr >= mem_lo
                        && txn_addr <= mem_hi;
    wire pref_hit_nxt = txn_valid && txn_addr >= pref_lo
                        && txn_addr <= pref_hi;
    wire err_fwd_nxt  = sec_err_msg && ctl_serr_fwd_en;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mperr_r     <= BSW_FLAG_RST;
            sig_abort_r <= BSW_FLAG_RST;
            rx_abort_r  <= BSW_FLAG_RST;
            rx_ur_r     <= BSW_FLAG_RST;
            rx_serr_r   <= BSW_FLAG_RST;
            det_perr_r  <= BSW_FLAG_RST;
        end else begin
            mperr_r     <= mperr_nxt;
            sig_abort_r <= sig_abort_nxt;
            rx_abort_r  <= rx_abort_nxt;
            rx_ur_r     <= rx_ur_nxt;
            rx_serr_r   <= rx_serr_nxt;
            det_perr_r  <= det_perr_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_base_r   <= BSW_ADDR_FIELD_RST;
            mem_limit_r  <= BSW_ADDR_FIELD_RST;
            pref_base_r  <= BSW_ADDR_FIELD_RST;
            pref_limit_r <= BSW_ADDR_FIELD_RST;
        end else begin
            mem_base_r   <= mem_base_nxt;
            mem_limit_r  <= mem_limit_nxt;
            pref_base_r  <= pref_base_nxt;
            pref_limit_r <= pref_limit_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata_r    <= 32'h00000000;
            cfg_ack_r      <= 1'b0;
            err_fwd_r      <= 1'b0;
            fwd_valid_r    <= 1'b0;
            fwd_mem_hit_r  <= 1'b0;
            fwd_pref_hit_r <= 1'b0;
        end else begin
            cfg_rdata_r    <= rdata_nxt;
            cfg_ack_r      <= cfg_rd_en || cfg_wr_en;
            err_fwd_r      <= err_fwd_nxt;
            fwd_valid_r    <= txn_valid;
            fwd_mem_hit_r  <= mem_hit_nxt;
            fwd_pref_hit_r <= pref_hit_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_rd_stat;
        cfg_rd_en && !cfg_wr_en && cfg_addr == BSW_OFS_SEC_STATUS;
    endsequence
    sequence s_rd_pref;
        cfg_rd_en && !cfg_wr_en && cfg_addr == BSW_OFS_PREF_WIN;
    endsequence

    property p_legacy_zero;
        s_rd_stat |=> cfg_ack_r && cfg_rdata_r[BSW_BIT_66MHZ] == 1'b0
            && cfg_rdata_r[BSW_BIT_FAST_B2B] == 1'b0
            && cfg_rdata_r[BSW_BIT_TIMING_HI:BSW_BIT_TIMING_LO] == 2'b00
            && cfg_rdata_r[20:16] == 5'b00000;
    endproperty
    a_legacy_zero: assert property (p_legacy_zero)
        else $error("legacy status bits not zero");

    property p_mperr_set;
        ev_parity_err && ctl_parity_resp_en |=> mperr_r;
    endproperty
    a_mperr_set: assert property (p_mperr_set)
        else $error("parity error did not set bit 24");

    property p_mperr_gate;
        $rose(mperr_r) |-> $past(ctl_parity_resp_en) && $past(ev_parity_err);
    endproperty
    a_mperr_gate: assert property (p_mperr_gate)
        else $error("bit 24 set without parity response");

    property p_sig_abort;
        ev_cpl_abort_sent |=> sig_abort_r [*3];
    endproperty
    a_sig_abort: assert property (p_sig_abort)
        else $error("signalled abort flag not held");

    property p_rx_abort_read;
        ev_rx_abort ##[1:8] s_rd_stat |=> cfg_rdata_r[BSW_BIT_RX_ABORT];
    endproperty
    a_rx_abort_read: assert property (p_rx_abort_read)
        else $error("received abort not readable");

    property p_rx_ur;
        ev_rx_ur |=> rx_ur_r;
    endproperty
    a_rx_ur: assert property (p_rx_ur)
        else $error("unsupported request flag not set");

    property p_serr;
        $rose(rx_serr_r) |-> $past(ev_err_msg_sent) && $past(ctl_serr_fwd_en);
    endproperty
    a_serr: assert property (p_serr)
        else $error("system error flag set without cause");

    property p_poison;
        ev_poison_rx && !ctl_parity_resp_en |=> det_perr_r;
    endproperty
    a_poison: assert property (p_poison)
        else $error("poisoned packet not flagged");

    property p_w1c;
        wr_stat && cfg_be[3] && cfg_wdata[BSW_BIT_DET_PERR] && !ev_poison_rx
            |=> !det_perr_r;
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear bit 31");

    property p_pref_ind;
        s_rd_pref |=> cfg_rdata_r[3:0] == BSW_PREF_IND_VAL
            && cfg_rdata_r[19:16] == BSW_PREF_IND_VAL;
    endproperty
    a_pref_ind: assert property (p_pref_ind)
        else $error("prefetch indicator not 1h");

    property p_mem_hit;
        txn_valid && txn_addr[63:32] == 32'h00000000
            && txn_addr[31:20] >= mem_base_r && txn_addr[31:20] <= mem_limit_r
            |=> fwd_valid_r && fwd_mem_hit_r;
    endproperty
    a_mem_hit: assert property (p_mem_hit)
        else $error("address inside memory window missed");

    property p_err_fwd;
        sec_err_msg |=> err_fwd_r == $past(ctl_serr_fwd_en);
    endproperty
    a_err_fwd: assert property (p_err_fwd)
        else $error("error forwarding ignores enable");

    ////////////////////////////////////////////////////////////////////////////
    // status, field and window checks; window bounds spelt out again from the fields, not from the decode wires
    sequence s_rd_mem;
        cfg_rd_en && !cfg_wr_en && cfg_addr == BSW_OFS_MEM_WIN;
    endsequence
    sequence s_wr_mem_all;
        wr_mem && cfg_be == 4'hF;
    endsequence
    sequence s_wr_pref_all;
        wr_pref && cfg_be == 4'hF;
    endsequence
    sequence s_txn_in_pref;
        txn_valid && txn_addr[63:32] == pref_base_upper
            && txn_addr[63:32] == pref_limit_upper
            && txn_addr[31:20] >= pref_base_r && txn_addr[31:20] <= pref_limit_r;
    endsequence

    property p_mperr_off;
        ev_parity_err && !ctl_parity_resp_en && !mperr_r |=> !mperr_r;
    endproperty
    a_mperr_off: assert property (p_mperr_off)
        else $error("bit 24 set with parity response off");

    property p_serr_off;
        ev_err_msg_sent && !ctl_serr_fwd_en && !rx_serr_r |=> !rx_serr_r;
    endproperty
    a_serr_off: assert property (p_serr_off)
        else $error("bit 30 set with forwarding off");

    property p_ro_sticky;
        !($fell(sig_abort_r) || $fell(rx_abort_r) || $fell(rx_ur_r));
    endproperty
    a_ro_sticky: assert property (p_ro_sticky)
        else $error("read-only status flag lost without reset");

    property p_set_wins;
        ev_poison_rx && wr_stat && cfg_be[3] && cfg_wdata[BSW_BIT_DET_PERR]
            |=> det_perr_r;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a poisoned packet in the same cycle");

    property p_mem_base_wr;
        s_wr_mem_all |=> mem_base_r == $past(cfg_wdata[15:4]);
    endproperty
    a_mem_base_wr: assert property (p_mem_base_wr)
        else $error("memory base field not written");

    property p_mem_limit_wr;
        s_wr_mem_all |=> mem_limit_r == $past(cfg_wdata[31:20]);
    endproperty
    a_mem_limit_wr: assert property (p_mem_limit_wr)
        else $error("memory limit field not written");

    property p_pref_base_wr;
        s_wr_pref_all |=> pref_base_r == $past(cfg_wdata[15:4]);
    endproperty
    a_pref_base_wr: assert property (p_pref_base_wr)
        else $error("prefetch base field not written");

    property p_pref_limit_wr;
        s_wr_pref_all |=> pref_limit_r == $past(cfg_wdata[31:20]);
    endproperty
    a_pref_limit_wr: assert property (p_pref_limit_wr)
        else $error("prefetch limit field not written");

    property p_mem_rsvd;
        s_rd_mem |=> cfg_rdata_r[3:0] == 4'h0 && cfg_rdata_r[19:16] == 4'h0;
    endproperty
    a_mem_rsvd: assert property (p_mem_rsvd)
        else $error("memory window reserved bits not zero");

    property p_pref_hit;
        s_txn_in_pref |=> fwd_valid_r && fwd_pref_hit_r;
    endproperty
    a_pref_hit: assert property (p_pref_hit)
        else $error("address inside prefetch window missed");

    property p_mem_upper;
        txn_valid && txn_addr[63:32] != 32'h00000000 |=> !fwd_mem_hit_r;
    endproperty
    a_mem_upper: assert property (p_mem_upper)
        else $error("memory window hit above the 32-bit space");

    property p_mem_below;
        txn_valid && txn_addr[31:20] < mem_base_r |=> !fwd_mem_hit_r;
    endproperty
    a_mem_below: assert property (p_mem_below)
        else $error("memory window hit below its base");

    property p_pref_above;
        txn_valid && txn_addr[63:32] == pref_limit_upper
            && txn_addr[31:20] > pref_limit_r |=> !fwd_pref_hit_r;
    endproperty
    a_pref_above: assert property (p_pref_above)
        else $error("prefetch window hit above its limit");

    property p_no_txn;
        !txn_valid |=> !fwd_valid_r && !fwd_mem_hit_r && !fwd_pref_hit_r;
    endproperty
    a_no_txn: assert property (p_no_txn)
        else $error("decode result without a transaction");

endmodule : bsw_regs

// file: bsw_regs_tb.sv
// Purpose: self-checking bench for the secondary status and window registers
// Assumes: config access, event and decode timing as given in the port notes
// Notes:   inputs set by blocking assignment at time 0, then driven by nonblocking assignment at rising edges; clock excepted
`timescale 1ns/1ns
module bsw_regs_tb
    import bsw_pkg::*;
;
    logic        sys_clk, rst_b, cfg_wr_en, cfg_rd_en;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, pref_base_upper, pref_limit_upper;
    logic [31:0] cfg_rdata_r;
    logic        cfg_ack_r, err_fwd_r, fwd_valid_r, fwd_mem_hit_r, fwd_pref_hit_r;
    logic        ctl_parity_resp_en, ctl_serr_fwd_en, txn_valid;
    logic [6:0]  ev;
    logic [63:0] txn_addr;
    int          n_mismatch = 0;
    int          compares   = 0;
    // edge cases of both windows: bottom, below, top, above, wrong upper half
    logic [63:0] ta [9] = '{64'h0000_0000_0010_0000, 64'h0000_0000_000F_FFFF,
        64'h0000_0000_002F_FFFF, 64'h0000_0000_0030_0000, 64'h0000_0001_0010_0000,
        64'h0000_0001_0030_0000, 64'h0000_0001_004F_FFFF, 64'h0000_0001_0050_0000,
        64'h0000_0001_002F_FFFF};
    logic [1:0]  te [9] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0};

    bsw_regs uut (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_wr_en(cfg_wr_en),
        .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata_r(cfg_rdata_r), .cfg_ack_r(cfg_ack_r),
        .ctl_parity_resp_en(ctl_parity_resp_en), .ctl_serr_fwd_en(ctl_serr_fwd_en),
        .ev_parity_err(ev[0]), .ev_cpl_abort_sent(ev[1]), .ev_rx_abort(ev[2]),
        .ev_rx_ur(ev[3]), .ev_err_msg_sent(ev[4]), .ev_poison_rx(ev[5]),
        .sec_err_msg(ev[6]), .err_fwd_r(err_fwd_r), .txn_valid(txn_valid),
        .txn_addr(txn_addr), .pref_base_upper(pref_base_upper),
        .pref_limit_upper(pref_limit_upper), .fwd_valid_r(fwd_valid_r),
        .fwd_mem_hit_r(fwd_mem_hit_r), .fwd_pref_hit_r(fwd_pref_hit_r));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    task automatic do_reset;
        @(posedge sys_clk) rst_b <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge sys_clk) {cfg_wr_en, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, be, d};
        @(posedge sys_clk) cfg_wr_en <= 1'b0;
        #1 chk(64'(cfg_ack_r), 64'h1, "write ack");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk) {cfg_rd_en, cfg_addr} <= {1'b1, a};
        @(posedge sys_clk) cfg_rd_en <= 1'b0;
        #1 chk(64'(cfg_ack_r), 64'h1, "read ack");
        chk(64'(cfg_rdata_r), 64'(exp), "read data");
    endtask : rd

    task automatic pulse(input int i);
        @(posedge sys_clk) ev[i] <= 1'b1;
        @(posedge sys_clk) ev <= 7'h00;
        #1;
    endtask : pulse

    task automatic dec(input logic [63:0] a, input logic [1:0] e);
        @(posedge sys_clk) {txn_valid, txn_addr} <= {1'b1, a};
        @(posedge sys_clk) txn_valid <= 1'b0;
        #1 chk(64'({fwd_valid_r, fwd_mem_hit_r, fwd_pref_hit_r}), 64'({1'b1, e}), "hit");
    endtask : dec

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, cfg_wr_en, cfg_rd_en, txn_valid, ev} = '0;
        {cfg_addr, cfg_be, cfg_wdata, txn_addr} = '0;
        {ctl_parity_resp_en, ctl_serr_fwd_en} = 2'h0;
        {pref_base_upper, pref_limit_upper} = {32'h0000_0001, 32'h0000_0001};
        do_reset();
        rd(BSW_OFS_SEC_STATUS, 32'h0000_0000);
        rd(BSW_OFS_MEM_WIN, 32'h0000_0000);
        rd(BSW_OFS_PREF_WIN, 32'h0001_0001);
        rd(8'h28, 32'h0000_0000);
        $display("test reset values done");
        wr(BSW_OFS_MEM_WIN, 4'hF, 32'hFFFF_FFFF);
        rd(BSW_OFS_MEM_WIN, 32'hFFF0_FFF0);
        wr(BSW_OFS_MEM_WIN, 4'h1, 32'h0000_0000);
        rd(BSW_OFS_MEM_WIN, 32'hFFF0_FF00);
        wr(BSW_OFS_MEM_WIN, 4'h4, 32'h0000_0000);
        rd(BSW_OFS_MEM_WIN, 32'hFF00_FF00);
        wr(BSW_OFS_PREF_WIN, 4'hF, 32'hFFFF_FFFF);
        rd(BSW_OFS_PREF_WIN, 32'hFFF1_FFF1);
        wr(BSW_OFS_SEC_STATUS, 4'hF, 32'hFFFF_FFFF);
        rd(BSW_OFS_SEC_STATUS, 32'h0000_0000);
        $display("test field access done");
        pulse(0);
        pulse(4);
        pulse(5);
        rd(BSW_OFS_SEC_STATUS, 32'h8000_0000);
        @(posedge sys_clk) {ctl_parity_resp_en, ctl_serr_fwd_en} <= 2'h3;
        for (int i = 0; i < 5; i++) pulse(i);
        rd(BSW_OFS_SEC_STATUS, 32'hF900_0000);
        wr(BSW_OFS_SEC_STATUS, 4'hF, 32'h0000_0000);
        wr(BSW_OFS_SEC_STATUS, 4'h7, 32'hFFFF_FFFF);
        rd(BSW_OFS_SEC_STATUS, 32'hF900_0000);
        wr(BSW_OFS_SEC_STATUS, 4'hF, 32'hFFFF_FFFF);
        rd(BSW_OFS_SEC_STATUS, 32'h3800_0000);
        // poison and its clear land on one edge; the set must win
        fork
            pulse(5);
            wr(BSW_OFS_SEC_STATUS, 4'h8, 32'h8000_0000);
        join
        rd(BSW_OFS_SEC_STATUS, 32'hB800_0000);
        $display("test status flags done");
        pulse(6);
        chk(64'(err_fwd_r), 64'h1, "forward on");
        @(posedge sys_clk) ctl_serr_fwd_en <= 1'b0;
        pulse(6);
        chk(64'(err_fwd_r), 64'h0, "forward off");
        $display("test error forwarding done");
        wr(BSW_OFS_MEM_WIN, 4'hF, 32'h0020_0010);
        wr(BSW_OFS_PREF_WIN, 4'hF, 32'h0040_0030);
        for (int i = 0; i < 9; i++) dec(ta[i], te[i]);
        $display("test window decode done");
        do_reset();
        rd(BSW_OFS_SEC_STATUS, 32'h0000_0000);
        rd(BSW_OFS_MEM_WIN, 32'h0000_0000);
        rd(BSW_OFS_PREF_WIN, 32'h0001_0001);
        $display("test second reset done");
        results();
    end

    // whole run is a little over a hundred cycles
    initial begin
        #200000;
        n_mismatch++;
        results();
    end
endmodule : bsw_regs_tb
